// ===== logic/ckps_pkg.sv
// Constants, field layout and carrier types of the clock prescale block
package ckps_pkg;
	localparam int DATA_W = 32;
	localparam int ADR_W = 6;
	localparam int CNT_W = 10;
	localparam int NUM_SRC = 6;

	localparam logic [3:0] IDX_SYS_SEL = 4'h0;
	localparam logic [3:0] IDX_PRESCALE = 4'h1;
	localparam logic [3:0] IDX_FREEZE = 4'h2;
	localparam logic [3:0] IDX_RTC = 4'h3;
	localparam logic [3:0] IDX_USB = 4'h4;
	localparam logic [3:0] IDX_PROTECT_KEY = 4'h8;
	localparam logic [3:0] IDX_STATUS = 4'h9;

	localparam logic [7:0] PROTECT_KEY = 8'hd8;
	localparam int PROTECT_WINDOW = 16;

	localparam logic [7:0] SYS_SEL_MASK = 8'h07;
	localparam logic [7:0] PRESCALE_MASK = 8'h7f;
	localparam logic [7:0] FREEZE_MASK = 8'h01;
	localparam logic [7:0] RTC_MASK = 8'h0f;
	localparam logic [7:0] USB_MASK = 8'h3f;
	localparam logic [7:0] RESET_VALUE = 8'h00;

	localparam logic [1:0] BC_1_1 = 2'h0;
	localparam logic [1:0] BC_1_2 = 2'h1;
	localparam logic [1:0] BC_4_1 = 2'h2;
	localparam logic [1:0] BC_2_2 = 2'h3;

	localparam logic [4:0] PSA_MAX_CODE = 5'h11;

	localparam logic [2:0] RTC_LOW_POWER_DIV = 3'h0;
	localparam logic [2:0] RTC_XTAL_DIV = 3'h1;
	localparam logic [2:0] RTC_RC32K_DIV = 3'h2;
	localparam logic [2:0] RTC_XTAL = 3'h5;
	localparam logic [2:0] RTC_RC32K = 3'h6;
	localparam logic [2:0] RTC_PIN = 3'h7;
	localparam logic [CNT_W-1:0] RTC_DIV_RATIO = 10'h020;
	localparam logic [CNT_W-1:0] RATIO_ONE = 10'h001;
	localparam logic [CNT_W-1:0] RATIO_TWO = 10'h002;
	localparam logic [CNT_W-1:0] RATIO_FOUR = 10'h004;

	localparam logic [1:0] USB_SRC_PLL = 2'h0;
	localparam logic [1:0] USB_SRC_INT_32MHZ = 2'h1;
	localparam logic [2:0] USB_DIV_MAX = 3'h5;

	// Bit order inside the source vector, low bit first
	localparam int SRC_LOW_POWER = 0;
	localparam int SRC_XTAL = 1;
	localparam int SRC_RC32K = 2;
	localparam int SRC_PIN = 3;
	localparam int SRC_PLL = 4;
	localparam int SRC_INT_32MHZ = 5;

	typedef struct packed {
		logic internal_32mhz_osc;
		logic pll;
		logic ext_pin;
		logic rc32k;
		logic xtal;
		logic ultra_low_power_osc;
	} ckps_src_type;

	typedef struct packed {
		logic periph_clk_x4;
		logic periph_clk_x2;
		logic cpu_core_clk;
	} ckps_tick_type;
endpackage

// ===== logic/ckps_edge.sv
// Two-stage synchroniser with rising edge pulse for one source clock
`timescale 1ns/10ps
`default_nettype none
module ckps_edge (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic level_i,
	output logic rise_o
);
	logic meta_q;
	logic sync_q;
	logic last_q;
	logic rise_q;

	always_ff @(posedge clk_i) begin
		meta_q <= level_i;
		sync_q <= meta_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Track the pin level so a high source gives no false edge
			last_q <= sync_q;
			rise_q <= 1'b0;
		end else begin
			last_q <= sync_q;
			rise_q <= sync_q & ~last_q;
		end
	end

	assign rise_o = rise_q;
endmodule
`default_nettype wire

// ===== logic/ckps_div.sv
// Tick divider: one output pulse per ratio input pulses
`timescale 1ns/10ps
`default_nettype none
module ckps_div #(
	parameter int CNT_W = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic [CNT_W-1:0] ratio_i,
	output logic tick_o
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] last;
	logic tick_q;

	generate
		if (CNT_W < 1) begin : g_bad_width
			$error("ckps_div: CNT_W must be at least 1");
		end
	endgenerate

	// A zero ratio behaves as no division
	assign last = (ratio_i == '0) ? '0 : ratio_i - CNT_W'(1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (tick_i) begin
			if (cnt_q >= last) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_i & (cnt_q >= last);
		end
	end

	assign tick_o = tick_q;
endmodule
`default_nettype wire

// ===== logic/ckps_top.sv
// Clock prescalers, selection lock, RTC and USB source selection
`timescale 1ns/10ps
`default_nettype none
module ckps_top #(
	parameter int PROTECT_CYCLES = ckps_pkg::PROTECT_WINDOW
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ckps_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [ckps_pkg::DATA_W-1:0] wb_dat_i,
	output logic [ckps_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire ckps_pkg::ckps_src_type src_clk_i,
	output logic [2:0] sys_clk_sel_o,
	output ckps_pkg::ckps_tick_type tick_o,
	output logic rtc_clk_tick_o,
	output logic usb_clk_tick_o,
	output logic clock_locked_o
);
	import ckps_pkg::*;

	generate
		if (PROTECT_CYCLES < 1 || PROTECT_CYCLES > 255) begin : g_bad_window
			$error("ckps_top: PROTECT_CYCLES must lie in 1..255");
		end
	endgenerate

	// Bus slave state
	logic ack_q;
	logic [DATA_W-1:0] dat_q;
	logic req;
	logic wr_commit;
	logic [3:0] idx;
	logic [7:0] wr_byte;
	logic [7:0] rd_byte;

	// Register contents
	logic [2:0] sys_sel_q;
	logic [1:0] prescale_b_c_div_q;
	logic [4:0] prescale_a_div_q;
	logic lock_q;
	logic [2:0] rt_counter_src_sel_q;
	logic rt_counter_src_on_q;
	logic [2:0] usb_clk_div_q;
	logic [1:0] usb_clk_src_sel_q;
	logic usb_clk_src_on_q;

	// Protected write window
	logic [7:0] window_q;
	logic window_open;
	logic protected_ok;

	// Derived tick chain
	logic [CNT_W-1:0] ratio_a;
	logic [CNT_W-1:0] ratio_b;
	logic [CNT_W-1:0] ratio_c;
	logic per4_tick;
	logic per2_tick;
	logic cpu_tick;

	// Source edges and selectors
	logic [NUM_SRC-1:0] src_level;
	logic [NUM_SRC-1:0] src_rise;
	logic rtc_raw;
	logic rtc_needs_div;
	logic rtc_valid;
	logic [CNT_W-1:0] rtc_ratio;
	logic rtc_tick;
	logic usb_raw;
	logic usb_valid;
	logic [CNT_W-1:0] usb_ratio;
	logic usb_tick;
	logic rtc_out_q;
	logic usb_out_q;

	// Bus decode: one aligned word per register, data in byte lane 0
	assign req = wb_cyc_i & wb_stb_i;
	assign idx = wb_adr_i[ADR_W-1:2];
	assign wr_byte = wb_dat_i[7:0];
	assign wr_commit = req & wb_we_i & ack_q & wb_sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// Reserved bits are masked so they always read zero
	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			IDX_SYS_SEL: rd_byte = {5'h00, sys_sel_q};
			IDX_PRESCALE: rd_byte = {1'b0, prescale_a_div_q, prescale_b_c_div_q};
			IDX_FREEZE: rd_byte = {7'h00, lock_q};
			IDX_RTC: rd_byte = {4'h0, rt_counter_src_sel_q, rt_counter_src_on_q};
			IDX_USB: rd_byte = {2'h0, usb_clk_div_q, usb_clk_src_sel_q,
				usb_clk_src_on_q};
			IDX_STATUS: rd_byte = {4'h0, usb_valid, rtc_valid, window_open,
				lock_q};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= '0;
		end else if (req & ~ack_q) begin
			dat_q <= {24'h000000, rd_byte};
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// Timed unlock: key write opens a short window for one protected write
	assign window_open = (window_q != 8'h00);
	assign protected_ok = window_open & ~lock_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			window_q <= 8'h00;
		end else if (wr_commit && idx == IDX_PROTECT_KEY &&
			wr_byte == PROTECT_KEY) begin
			window_q <= 8'(PROTECT_CYCLES);
		end else if (wr_commit && window_open &&
			(idx == IDX_SYS_SEL || idx == IDX_PRESCALE || idx == IDX_FREEZE)) begin
			window_q <= 8'h00;
		end else if (window_open) begin
			window_q <= window_q - 8'h01;
		end
	end

	// System clock selection, frozen by the lock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_sel_q <= RESET_VALUE[2:0];
		end else if (wr_commit && idx == IDX_SYS_SEL && protected_ok) begin
			sys_sel_q <= wr_byte[2:0] & SYS_SEL_MASK[2:0];
		end
	end

	// Prescaler settings, frozen by the lock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prescale_a_div_q <= RESET_VALUE[6:2];
			prescale_b_c_div_q <= RESET_VALUE[1:0];
		end else if (wr_commit && idx == IDX_PRESCALE && protected_ok) begin
			prescale_a_div_q <= wr_byte[6:2] & PRESCALE_MASK[6:2];
			prescale_b_c_div_q <= wr_byte[1:0];
		end
	end

	// Lock can only be set, only with the key, and only reset clears it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_q <= RESET_VALUE[0];
		end else if (wr_commit && idx == IDX_FREEZE && window_open &&
			(wr_byte[0] & FREEZE_MASK[0])) begin
			lock_q <= 1'b1;
		end
	end

	// RTC source control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rt_counter_src_sel_q <= RESET_VALUE[3:1];
			rt_counter_src_on_q <= RESET_VALUE[0];
		end else if (wr_commit && idx == IDX_RTC) begin
			rt_counter_src_sel_q <= wr_byte[3:1] & RTC_MASK[3:1];
			rt_counter_src_on_q <= wr_byte[0];
		end
	end

	// USB source control; divider held while the source is enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			usb_clk_div_q <= RESET_VALUE[5:3];
			usb_clk_src_sel_q <= RESET_VALUE[2:1];
			usb_clk_src_on_q <= RESET_VALUE[0];
		end else if (wr_commit && idx == IDX_USB) begin
			if (!usb_clk_src_on_q) begin
				usb_clk_div_q <= wr_byte[5:3] & USB_MASK[5:3];
			end
			usb_clk_src_sel_q <= wr_byte[2:1];
			usb_clk_src_on_q <= wr_byte[0];
		end
	end

	assign sys_clk_sel_o = sys_sel_q;
	assign clock_locked_o = lock_q;

	// Prescaler A: odd codes up to the top code give powers of two
	function automatic logic [CNT_W-1:0] psa_ratio(input logic [4:0] code);
		logic [3:0] shift;
		shift = 4'(({1'b0, code} + 6'h01) >> 1);
		if (code == 5'h00) begin
			psa_ratio = RATIO_ONE;
		end else if (code[0] && code <= PSA_MAX_CODE) begin
			psa_ratio = RATIO_ONE << shift;
		end else begin
			psa_ratio = RATIO_ONE;
		end
	endfunction

	assign ratio_a = psa_ratio(prescale_a_div_q);

	always_comb begin
		ratio_b = RATIO_ONE;
		ratio_c = RATIO_ONE;
		unique case (prescale_b_c_div_q)
			BC_1_1: begin
				ratio_b = RATIO_ONE;
				ratio_c = RATIO_ONE;
			end
			BC_1_2: begin
				ratio_b = RATIO_ONE;
				ratio_c = RATIO_TWO;
			end
			BC_4_1: begin
				ratio_b = RATIO_FOUR;
				ratio_c = RATIO_ONE;
			end
			BC_2_2: begin
				ratio_b = RATIO_TWO;
				ratio_c = RATIO_TWO;
			end
		endcase
	end

	ckps_div #(.CNT_W(CNT_W)) u_div_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(1'b1),
		.ratio_i(ratio_a),
		.tick_o(per4_tick)
	);

	ckps_div #(.CNT_W(CNT_W)) u_div_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(per4_tick),
		.ratio_i(ratio_b),
		.tick_o(per2_tick)
	);

	ckps_div #(.CNT_W(CNT_W)) u_div_c (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(per2_tick),
		.ratio_i(ratio_c),
		.tick_o(cpu_tick)
	);

	assign tick_o.periph_clk_x4 = per4_tick;
	assign tick_o.periph_clk_x2 = per2_tick;
	assign tick_o.cpu_core_clk = cpu_tick;

	// Source clocks come from other domains and are turned into edge pulses
	assign src_level = src_clk_i;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
			ckps_edge u_edge (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.level_i(src_level[gi]),
				.rise_o(src_rise[gi])
			);
		end
	endgenerate

	// RTC source selector
	always_comb begin
		rtc_raw = 1'b0;
		rtc_needs_div = 1'b0;
		rtc_valid = 1'b0;
		unique case (rt_counter_src_sel_q)
			RTC_LOW_POWER_DIV: begin
				rtc_raw = src_rise[SRC_LOW_POWER];
				rtc_needs_div = 1'b1;
				rtc_valid = 1'b1;
			end
			RTC_XTAL_DIV: begin
				rtc_raw = src_rise[SRC_XTAL];
				rtc_needs_div = 1'b1;
				rtc_valid = 1'b1;
			end
			RTC_RC32K_DIV: begin
				rtc_raw = src_rise[SRC_RC32K];
				rtc_needs_div = 1'b1;
				rtc_valid = 1'b1;
			end
			RTC_XTAL: begin
				rtc_raw = src_rise[SRC_XTAL];
				rtc_valid = 1'b1;
			end
			RTC_RC32K: begin
				rtc_raw = src_rise[SRC_RC32K];
				rtc_valid = 1'b1;
			end
			RTC_PIN: begin
				rtc_raw = src_rise[SRC_PIN];
				rtc_valid = 1'b1;
			end
			default: begin
				rtc_raw = 1'b0;
				rtc_needs_div = 1'b0;
				rtc_valid = 1'b0;
			end
		endcase
	end

	assign rtc_ratio = rtc_needs_div ? RTC_DIV_RATIO : RATIO_ONE;

	ckps_div #(.CNT_W(CNT_W)) u_div_rtc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(rtc_raw & rt_counter_src_on_q),
		.ratio_i(rtc_ratio),
		.tick_o(rtc_tick)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rtc_out_q <= 1'b0;
		end else begin
			rtc_out_q <= rtc_tick & rt_counter_src_on_q & rtc_valid;
		end
	end

	// USB source selector and prescaler
	always_comb begin
		usb_raw = 1'b0;
		unique case (usb_clk_src_sel_q)
			USB_SRC_PLL: usb_raw = src_rise[SRC_PLL];
			USB_SRC_INT_32MHZ: usb_raw = src_rise[SRC_INT_32MHZ];
			default: usb_raw = 1'b0;
		endcase
	end

	assign usb_valid = (usb_clk_div_q <= USB_DIV_MAX) &&
		(usb_clk_src_sel_q == USB_SRC_PLL ||
		usb_clk_src_sel_q == USB_SRC_INT_32MHZ);
	assign usb_ratio = RATIO_ONE << usb_clk_div_q;

	ckps_div #(.CNT_W(CNT_W)) u_div_usb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(usb_raw & usb_clk_src_on_q),
		.ratio_i(usb_ratio),
		.tick_o(usb_tick)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			usb_out_q <= 1'b0;
		end else begin
			usb_out_q <= usb_tick & usb_clk_src_on_q & usb_valid;
		end
	end

	assign rtc_clk_tick_o = rtc_out_q;
	assign usb_clk_tick_o = usb_out_q;
endmodule
`default_nettype wire

// ===== verification/ckps_props.sv
// Port assertions for the clock prescale block
`timescale 1ns/10ps
`default_nettype none
module ckps_props
	import ckps_pkg::*;
#(
	parameter int PROTECT_CYCLES = PROTECT_WINDOW
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [DATA_W-1:0] wb_dat_i,
	input wire logic [DATA_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire ckps_src_type src_clk_i,
	input wire logic [2:0] sys_clk_sel_o,
	input wire ckps_tick_type tick_o,
	input wire logic rtc_clk_tick_o,
	input wire logic usb_clk_tick_o,
	input wire logic clock_locked_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_once_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	AST_REQ_ACK: assert property (req_s |=> ack_once_s)
		else $error("ack not a single pulse after request");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read data not zero");
	AST_RTC_RSVD: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i[5:2] == IDX_RTC |-> wb_dat_o[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	AST_LOCK_STAY: assert property (clock_locked_o |=> clock_locked_o)
		else $error("lock fell without reset");
	AST_SEL_FROZEN: assert property (clock_locked_o |=>
		$stable(sys_clk_sel_o))
		else $error("selection changed while locked");
	AST_LOCK_CAUSE: assert property ($rose(clock_locked_o) |->
		$past(wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[0] &&
		wb_adr_i[5:2] == IDX_FREEZE))
		else $error("lock set without a lock write");
	AST_SEL_CAUSE: assert property ($changed(sys_clk_sel_o) |->
		$past(wb_ack_o && wb_we_i && wb_adr_i[5:2] == IDX_SYS_SEL))
		else $error("selection changed without a write");
	AST_X2_CHAIN: assert property (tick_o.periph_clk_x2 |->
		$past(tick_o.periph_clk_x4))
		else $error("x2 tick without x4 tick");
	AST_CPU_CHAIN: assert property (tick_o.cpu_core_clk |->
		$past(tick_o.periph_clk_x2))
		else $error("cpu tick without x2 tick");
endmodule
bind ckps_top ckps_props #(.PROTECT_CYCLES(PROTECT_CYCLES)) i_ckps_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.src_clk_i(src_clk_i), .sys_clk_sel_o(sys_clk_sel_o), .tick_o(tick_o),
	.rtc_clk_tick_o(rtc_clk_tick_o), .usb_clk_tick_o(usb_clk_tick_o),
	.clock_locked_o(clock_locked_o)
);
`default_nettype wire

// ===== verification/tb_ckps_top.sv
// Self-checking bench for the clock prescale block
`timescale 1ns/10ps
`default_nettype none
module tb_ckps_top;
	import ckps_pkg::*;
	localparam int PW = 8;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [5:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rdat, q;
	logic [7:0] v;
	logic [2:0] ssel;
	logic ack, lck, rtk, utk;
	logic [4:0] scnt = '0;
	ckps_src_type src = '0;
	ckps_tick_type tk;
	int fails = 0, check_count = 0;
	int c[5] = '{default: 0}, b[5], d[5];
	ckps_top #(.PROTECT_CYCLES(PW)) i_ckps_top (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .src_clk_i(src),
		.sys_clk_sel_o(ssel), .tick_o(tk), .rtc_clk_tick_o(rtk),
		.usb_clk_tick_o(utk), .clock_locked_o(lck)
	);
	initial forever #10 clk_i = ~clk_i;
	// Sources: periods 4, 8, 16, 32 clocks so a wrong pick shows in the rate
	always @(posedge clk_i) begin
		scnt <= scnt + 5'h01;
		// Bit 5 models the 32 MHz source as already tuned to its USB rate
		src <= {scnt[2], scnt[1], scnt[4], scnt[3], scnt[2], scnt[1]};
		c[0] <= c[0] + int'(tk.periph_clk_x4);
		c[1] <= c[1] + int'(tk.periph_clk_x2);
		c[2] <= c[2] + int'(tk.cpu_core_clk);
		c[3] <= c[3] + int'(rtk);
		c[4] <= c[4] + int'(utk);
	end
	task automatic check(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] x);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= {24'h0, x};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		#1;
	endtask
	task automatic rd(input string n, input logic [5:0] a, input logic [7:0] e);
		wb(0, a, 8'h00);
		check(n, q, {24'h0, e});
	endtask
	task automatic reset_dut();
		@(posedge clk_i);
		rst_i <= 1;
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic win(input int w);
		repeat (300) @(posedge clk_i);
		b = c;
		repeat (w) @(posedge clk_i);
		d = c;
		foreach (d[i]) d[i] -= b[i];
	endtask
	function automatic logic [31:0] near(input int a, e);
		return (e == 0) ? 32'(a == 0) : 32'(a >= e - 1 && a <= e + 1);
	endfunction
	function automatic int rtc_exp(input int k, w);
		case (k)
			0: return w / 128;
			1: return w / 256;
			2: return w / 512;
			5: return w / 8;
			6: return w / 16;
			7: return w / 32;
			default: return 0;
		endcase
	endfunction
	function automatic int usb_exp(input int s, dv, w);
		if (s > 1 || dv > 5)
			return 0;
		return (w / (s == 0 ? 4 : 8)) >> dv;
	endfunction
	function automatic int bc_exp(input int k, input bit cpu);
		int r;
		r = (k == 4) ? 128 : 256 / (k == 2 ? 4 : k == 3 ? 2 : 1);
		return (cpu && k % 2 == 1) ? r / 2 : r;
	endfunction
	initial begin
		repeat (90000) @(posedge clk_i);
		fails++;
		final_report();
	end
	initial begin
		void'($urandom(32'h72d57ad0));
		reset_dut();
		for (int i = 0; i < 5; i++)
			rd("reset_val", 6'(i * 4), 8'h00);
		wb(1, 6'h3c, 8'hff);
		rd("unmapped", 6'h3c, 8'h00);
		repeat (6) begin
			v = 8'($urandom);
			wb(1, 6'h0c, v);
			rd("rtc_rw", 6'h0c, v & RTC_MASK);
		end
		wb(1, 6'h10, 8'hff);
		rd("usb_rsvd", 6'h10, 8'h3f);
		wb(1, 6'h10, 8'h01);
		rd("usb_div_held", 6'h10, 8'h39);
		wb(1, 6'h10, 8'h00);
		rd("usb_off", 6'h10, 8'h38);
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin
			wb(1, 6'h0c, 8'(k * 2 + 1));
			win(1024);
			check("rtc_rate", near(d[3], rtc_exp(k, 1024)), 1);
		end
		wb(1, 6'h0c, 8'h0a);
		win(1024);
		check("rtc_off", 32'(d[3]), 0);
		$display("test rtc done");
		for (int k = 0; k < 32; k++) begin
			wb(1, 6'h10, 8'(k * 2));
			wb(1, 6'h10, 8'(k * 2 + 1));
			win(512);
			check("usb_rate", near(d[4], usb_exp(k % 4, k / 4, 512)), 1);
		end
		wb(1, 6'h10, 8'h00);
		win(512);
		check("usb_off", 32'(d[4]), 0);
		$display("test usb done");
		for (int k = 0; k < 5; k++) begin
			wb(1, 6'h20, PROTECT_KEY);
			wb(1, 6'h04, k < 4 ? 8'(k) : 8'h04);
			win(256);
			check("x4_rate", near(d[0], k < 4 ? 256 : 128), 1);
			check("x2_rate", near(d[1], bc_exp(k, 0)), 1);
			check("cpu_rate", near(d[2], bc_exp(k, 1)), 1);
		end
		$display("test prescale done");
		wb(1, 6'h08, 8'h01);
		check("lock_nokey", lck, 0);
		wb(1, 6'h20, PROTECT_KEY);
		rd("status_open", 6'h24, 8'h06);
		repeat (PW + 2) @(posedge clk_i);
		wb(1, 6'h08, 8'h01);
		check("lock_late", lck, 0);
		v = 8'($urandom) & SYS_SEL_MASK;
		wb(1, 6'h20, PROTECT_KEY);
		wb(1, 6'h00, v);
		wb(1, 6'h20, PROTECT_KEY);
		wb(1, 6'h08, 8'hff);
		check("lock_set", lck, 1);
		rd("lock_rd", 6'h08, 8'h01);
		rd("status_lock", 6'h24, 8'h05);
		wb(1, 6'h20, PROTECT_KEY);
		wb(1, 6'h00, ~v);
		rd("sel_frozen", 6'h00, v);
		check("sel_pin", ssel, v[2:0]);
		wb(1, 6'h20, PROTECT_KEY);
		wb(1, 6'h04, 8'h03);
		rd("ps_frozen", 6'h04, 8'h04);
		wb(1, 6'h20, PROTECT_KEY);
		wb(1, 6'h08, 8'h00);
		check("lock_keep", lck, 1);
		reset_dut();
		check("lock_clr", lck, 0);
		$display("test lock done");
		final_report();
	end
endmodule
`default_nettype wire
